// ==== dv/pulse_source.sv ====
// Purpose: behavioural encoder and pulse source on the counter pins
// Assumes: each level is held two clocks, the fastest legal edge rate
// Notes:   pin 0 clock/A/up, pin 1 direction/B/down, pin 2 reset/Z
`timescale 1ns/100ps
module pulse_source (
	input wire logic CLOCK,
	output logic [2:0] PINS
);
	int ph;
	initial begin
		PINS = 3'h0;
		ph = 0;
	end
	// ************************************************************
	// level and pulse drivers
	// ************************************************************
	// hold two clocks so no edge is closer than the pins allow
	task set(input int p, input logic v);
		@(posedge CLOCK);
		PINS[p] <= v;
		@(posedge CLOCK);
	endtask
	task pulse(input int p, input int n);
		repeat (n) begin
			set(p, 1'b1);
			set(p, 1'b0);
		end
	endtask
	// gray steps, A leads B going up
	task quad(input logic up, input int n);
		repeat (n) begin
			ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
			@(posedge CLOCK);
			PINS[1:0] <= {ph[1], ph[1] ^ ph[0]};
			@(posedge CLOCK);
		end
	endtask
endmodule

// ==== dv/tb.sv ====
// Purpose: self-checking bench of the fast pulse counter
// Assumes: short measuring windows of 10, 100 and 1000 clocks
// Notes:   counts are read on the port, registers over the bus
`timescale 1ns/100ps
`define PK fast_pulse_counter_pkg::
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_fail++; \
	$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end
module tb;
	logic CLOCK, RESET, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, OUT_ACTIVE;
	logic [5:0] AVS_ADDRESS;
	logic [31:0] AVS_WRITEDATA, AVS_READDATA, COUNT_VALUE, FREQ_VALUE, c0;
	logic [3:0] AVS_BYTEENABLE;
	logic [2:0] IN_PINS, PINS_FREE;
	fast_pulse_counter_pkg::events_t EVENT_PULSE;
	int n_fail, num_checks, eq_seen;

	fast_pulse_counter #(.TICKS_10MS(10), .TICKS_100MS(100), .TICKS_1S(1000)) dut_u (
		.CLOCK(CLOCK), .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IN_PINS(IN_PINS),
		.OUT_ACTIVE(OUT_ACTIVE), .COUNT_VALUE(COUNT_VALUE), .FREQ_VALUE(FREQ_VALUE),
		.EVENT_PULSE(EVENT_PULSE), .PINS_FREE(PINS_FREE));
	pulse_source src_u (.CLOCK(CLOCK), .PINS(IN_PINS));

	initial begin
		CLOCK = 1'b0;
		forever #20 CLOCK = ~CLOCK;
	end
	always @(posedge CLOCK) begin
		if (EVENT_PULSE.eq === 1'b1) eq_seen++;
	end
	// ************************************************************
	// bus master and helpers
	// ************************************************************
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE <= 1'b1;
		do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
		AVS_WRITE <= 1'b0;
	endtask
	task automatic rc(input logic [5:0] a, input logic [31:0] e);
		logic [31:0] d;
		@(posedge CLOCK);
		AVS_ADDRESS <= a;
		AVS_READ <= 1'b1;
		do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
		d = AVS_READDATA;
		AVS_READ <= 1'b0;
		`CHK(d, e);
	endtask
	task automatic st(input logic [15:0] e);
		rc(`PK OFS_STATUS, {16'h0000, e});
	endtask
	task automatic ld(input logic [15:0] d, input logic [31:0] cv, rv, input logic [15:0] p, input logic [3:0] f);
		wr(`PK OFS_NEW_DIR, {16'h0000, d});
		wr(`PK OFS_REQUESTED_COUNT, cv);
		wr(`PK OFS_REQUESTED_REFERENCE, rv);
		wr(`PK OFS_NEW_PERIOD, {16'h0000, p});
		wr(`PK OFS_UPDATE, {28'h0000000, f});
	endtask
	task automatic settle;
		repeat (6) @(posedge CLOCK);
	endtask
	task automatic complete_run;
		if (n_fail == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset;
		wr(`PK OFS_COUNT, 32'h00000005);
		rc(`PK OFS_COUNT, `PK COUNT_RESET);
		rc(`PK OFS_REF, `PK REF_RESET);
		rc(`PK OFS_FREQ, 32'h00000000);
		rc(6'h3C, 32'h00000000);
		st(`PK STAT_OK);
		`CHK(PINS_FREE, 3'h6);
		`CHK(OUT_ACTIVE, 1'b0);
	endtask
	task automatic t_int_dir;
		src_u.pulse(0, 3);
		settle;
		`CHK(COUNT_VALUE, 32'h00000003);
		src_u.pulse(1, 2);
		settle;
		`CHK(COUNT_VALUE, 32'h00000003);
		ld(`PK DIR_BWD, 32'h0, 32'h0, `PK NEW_PERIOD_10MS, 4'h1);
		src_u.pulse(0, 2);
		settle;
		`CHK(COUNT_VALUE, 32'h00000001);
		rc(`PK OFS_EVENTS, 32'h00000004);
		wr(`PK OFS_EVENTS, 32'h00000007);
		rc(`PK OFS_EVENTS, 32'h00000000);
	endtask
	task automatic t_status;
		ld(16'h0002, 32'h00000009, 32'h0, `PK NEW_PERIOD_10MS, 4'h3);
		st(`PK STAT_BAD_DIR);
		`CHK(COUNT_VALUE, 32'h00000001);
		ld(`PK DIR_FWD, 32'h0, 32'h0, `PK NEW_PERIOD_100MS, 4'h8);
		st(`PK STAT_BAD_PERIOD);
	endtask
	task automatic t_ref_eq;
		ld(`PK DIR_FWD, 32'h0, 32'h00000002, `PK NEW_PERIOD_10MS, 4'h7);
		st(`PK STAT_OK);
		rc(`PK OFS_REF, 32'h00000002);
		`CHK(COUNT_VALUE, 32'h00000000);
		`CHK(OUT_ACTIVE, 1'b1);
		eq_seen = 0;
		src_u.pulse(0, 4);
		settle;
		`CHK(eq_seen, 1);
		`CHK(OUT_ACTIVE, 1'b0);
		// the first up step after the earlier down steps also flags a direction change
		rc(`PK OFS_EVENTS, 32'h00000005);
		ld(`PK DIR_FWD, 32'h0, 32'h00000006, `PK NEW_PERIOD_10MS, 4'h4);
		settle;
		`CHK(OUT_ACTIVE, 1'b1);
		wr(`PK OFS_EVENTS, 32'h00000007);
	endtask
	task automatic t_ext;
		wr(`PK OFS_CTRL, 32'h00000001);
		settle;
		`CHK(PINS_FREE, 3'h4);
		c0 = COUNT_VALUE;
		src_u.pulse(0, 3);
		settle;
		`CHK(COUNT_VALUE, c0 - 32'h3);
		src_u.set(1, 1'b1);
		src_u.pulse(0, 2);
		settle;
		`CHK(COUNT_VALUE, c0 - 32'h1);
		src_u.set(1, 1'b0);
	endtask
	task automatic t_two;
		wr(`PK OFS_CTRL, 32'h00000002);
		settle;
		c0 = COUNT_VALUE;
		src_u.pulse(0, 3);
		src_u.pulse(1, 1);
		settle;
		`CHK(COUNT_VALUE, c0 + 32'h2);
		`CHK(PINS_FREE, 3'h4);
	endtask
	task automatic t_quad;
		wr(`PK OFS_CTRL, 32'h00000003);
		settle;
		c0 = COUNT_VALUE;
		src_u.quad(1'b1, 8);
		src_u.quad(1'b0, 3);
		settle;
		`CHK(COUNT_VALUE, c0 + 32'h5);
		wr(`PK OFS_CTRL, 32'h00000033);
		settle;
		`CHK(PINS_FREE, 3'h0);
		src_u.set(2, 1'b1);
		settle;
		`CHK(COUNT_VALUE, 32'h00000000);
		// count crossed the reference of 6 in the two clock and quadrature runs
		rc(`PK OFS_EVENTS, 32'h00000007);
		src_u.quad(1'b1, 4);
		ld(`PK DIR_FWD, 32'h00000007, 32'h00000006, `PK NEW_PERIOD_10MS, 4'h2);
		settle;
		`CHK(COUNT_VALUE, 32'h00000000);
		src_u.set(2, 1'b0);
		src_u.quad(1'b1, 4);
		settle;
		`CHK(COUNT_VALUE, 32'h00000004);
		wr(`PK OFS_EVENTS, 32'h00000007);
	endtask
	task automatic t_pto;
		wr(`PK OFS_CTRL, 32'h00000004);
		settle;
		`CHK(PINS_FREE, 3'h4);
		src_u.set(0, 1'b0);
		src_u.set(1, 1'b1);
		settle;
		c0 = COUNT_VALUE;
		src_u.pulse(0, 5);
		settle;
		`CHK(COUNT_VALUE, c0 + 32'h5);
	endtask
	task automatic t_freq;
		logic [15:0] per[3] = '{`PK NEW_PERIOD_10MS, `PK NEW_PERIOD_100MS, `PK NEW_PERIOD_1S};
		int tk[3] = '{10, 100, 1000};
		int tol[3] = '{50, 10, 1};
		wr(`PK OFS_CTRL, 32'h00000040);
		// a pulse every four clocks is 250 per 1000 ticks on every window
		for (int i = 0; i < 3; i++) begin
			ld(`PK DIR_FWD, 32'h0, 32'h00000006, per[i], 4'h8);
			st(`PK STAT_OK);
			fork
				src_u.pulse(0, tk[i] / 2 + 10);
				begin
					repeat (2 * tk[i] + 10) @(posedge CLOCK);
					`CHK((FREQ_VALUE >= 32'h000000FA - 32'(tol[i])) && (FREQ_VALUE <= 32'h000000FA + 32'(tol[i])), 1'b1);
				end
			join
		end
	endtask
	// ************************************************************
	// main sequence and watchdog
	// ************************************************************
	initial begin
		RESET = 1'b1;
		AVS_ADDRESS = 6'h00;
		AVS_READ = 1'b0;
		AVS_WRITE = 1'b0;
		AVS_WRITEDATA = 32'h00000000;
		AVS_BYTEENABLE = 4'hF;
		n_fail = 0;
		num_checks = 0;
		eq_seen = 0;
		repeat (10) @(posedge CLOCK);
		RESET <= 1'b0;
		t_reset;
		t_int_dir;
		t_status;
		t_ref_eq;
		t_ext;
		t_two;
		t_quad;
		t_pto;
		t_freq;
		complete_run;
	end
	// the whole sequence needs well under 8000 clocks
	initial begin
		repeat (20000) @(posedge CLOCK);
		n_fail++;
		complete_run;
	end
endmodule

// ==== verilog/fast_pulse_counter.sv ====
// Purpose: fast pulse counter with frequency report and Avalon-MM registers
// Assumes: pins IN_PINS are asynchronous and pass two flip-flops first
// Notes:   IN_PINS[0] clock/A/up, [1] direction/B/down, [2] reset/Z
`timescale 1ns/100ps
module fast_pulse_counter #(
	parameter int TICKS_10MS = fast_pulse_counter_pkg::TICKS_10MS,
	parameter int TICKS_100MS = fast_pulse_counter_pkg::TICKS_100MS,
	parameter int TICKS_1S = fast_pulse_counter_pkg::TICKS_1S
) (
	input wire logic CLOCK,
	input wire logic RESET,
	input wire logic [5:0] AVS_ADDRESS,
	input wire logic AVS_READ,
	input wire logic AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0] AVS_BYTEENABLE,
	output logic [31:0] AVS_READDATA,
	output logic AVS_WAITREQUEST,
	input wire logic [2:0] IN_PINS,
	output logic OUT_ACTIVE,
	output logic [31:0] COUNT_VALUE,
	output logic [31:0] FREQ_VALUE,
	output fast_pulse_counter_pkg::events_t EVENT_PULSE,
	output logic [2:0] PINS_FREE
);
	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] scale(input logic [31:0] x, input logic [1:0] sel);
		case (sel)
			2'h0: scale = 32'(x * 32'h00000064);
			2'h1: scale = 32'(x * 32'h0000000A);
			default: scale = x;
		endcase
	endfunction

	// three window lengths
	// lengths are clock counts, so the defaults follow the system clock
	function automatic logic [24:0] period_ticks(input logic [1:0] sel);
		case (sel)
			2'h0: period_ticks = 25'(TICKS_10MS);
			2'h1: period_ticks = 25'(TICKS_100MS);
			default: period_ticks = 25'(TICKS_1S);
		endcase
	endfunction

	fast_pulse_counter_pkg::state_t q, s;
	fast_pulse_counter_pkg::mode_t mode;
	logic [2:0] rise;
	logic [2:0] chg;
	logic req;
	logic rst_en;
	logic rst_act;
	logic freq_mode;
	logic step;
	logic up;
	logic wr_fire;
	logic upd_fire;
	logic [3:0] flags;
	logic bad_dir;
	logic bad_per;
	logic [31:0] wmerged;

	assign mode = fast_pulse_counter_pkg::mode_t'(q.ctrl[2:0]);
	// edges seen only past the second flip-flop
	assign rise = q.sync2 & ~q.prev;
	assign chg = q.sync2 ^ q.prev;
	assign req = AVS_READ | AVS_WRITE;
	assign rst_en = q.ctrl[fast_pulse_counter_pkg::CTRL_RST_EN_BIT] && mode != fast_pulse_counter_pkg::MODE_PTO_MON;
	// level-sensitive hold; pin 2 is the index in quadrature
	assign rst_act = rst_en && (q.sync2[2] == q.ctrl[fast_pulse_counter_pkg::CTRL_RST_HIGH_BIT]);
	// frequency excluded with reset input or in monitor mode
	assign freq_mode = q.ctrl[fast_pulse_counter_pkg::CTRL_FREQ_BIT] && !rst_en
		&& mode != fast_pulse_counter_pkg::MODE_PTO_MON;
	assign wr_fire = q.bus == fast_pulse_counter_pkg::BUS_ACK && AVS_WRITE;
	assign upd_fire = wr_fire && AVS_ADDRESS == fast_pulse_counter_pkg::OFS_UPDATE;
	assign wmerged = merge(32'h00000000, AVS_WRITEDATA, AVS_BYTEENABLE);
	assign flags = wmerged[3:0];
	assign bad_dir = flags[fast_pulse_counter_pkg::UPD_DIR_BIT] && q.new_dir != fast_pulse_counter_pkg::DIR_FWD
		&& q.new_dir != fast_pulse_counter_pkg::DIR_BWD;
	// three values and frequency mode only
	assign bad_per = flags[fast_pulse_counter_pkg::UPD_PER_BIT] && (!freq_mode
		|| (q.new_period != fast_pulse_counter_pkg::NEW_PERIOD_10MS
		&& q.new_period != fast_pulse_counter_pkg::NEW_PERIOD_100MS
		&& q.new_period != fast_pulse_counter_pkg::NEW_PERIOD_1S));

	// ************************************************************
	// counting mode decode
	// ************************************************************
	always_comb begin
		step = 1'b0;
		up = 1'b1;
		// mode select, identical in every instance
		case (mode)
			fast_pulse_counter_pkg::MODE_INT_DIR: begin
				step = rise[0];
				up = !q.dir_down;
			end
			fast_pulse_counter_pkg::MODE_EXT_DIR, fast_pulse_counter_pkg::MODE_PTO_MON: begin
				// direction pin high counts up; monitor uses the same pair
				step = rise[0];
				up = q.sync2[1];
			end
			fast_pulse_counter_pkg::MODE_TWO_CLK: begin
				// simultaneous up and down edges cancel
				step = rise[0] ^ rise[1];
				up = rise[0];
			end
			fast_pulse_counter_pkg::MODE_QUAD: begin
				// one phase changes per valid step
				step = chg[0] ^ chg[1];
				up = q.sync2[0] ^ q.prev[1];
			end
			default: begin
				step = 1'b0;
				up = 1'b1;
			end
		endcase
	end

	// pins the current mode leaves unused
	always_comb begin
		case (mode)
			fast_pulse_counter_pkg::MODE_INT_DIR: PINS_FREE = {!rst_en, 1'b1, 1'b0};
			fast_pulse_counter_pkg::MODE_PTO_MON: PINS_FREE = 3'h4;
			fast_pulse_counter_pkg::MODE_EXT_DIR, fast_pulse_counter_pkg::MODE_TWO_CLK,
			fast_pulse_counter_pkg::MODE_QUAD: PINS_FREE = {!rst_en, 2'b00};
			default: PINS_FREE = 3'h7;
		endcase
	end

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		s = q;
		s.pulse = '0;
		// pins reach the count only through these flops, no override path
		s.sync1 = IN_PINS;
		s.sync2 = q.sync1;
		s.prev = q.sync2;

		if (rst_act) begin
			s.count = '0;
		end else if (step) begin
			s.count = up ? q.count + 32'sh00000001 : q.count - 32'sh00000001;
		end
		s.rst_prev = rst_act;
		s.pulse.rst = rst_act && !q.rst_prev;
		if (step && !rst_act) begin
			s.last_down = !up;
			s.pulse.dir = (up == q.last_down);
		end

		// window total, published at window end
		if (freq_mode) begin
			if (q.timer >= period_ticks(q.per_sel) - 25'h0000001) begin
				s.freq = scale(q.acc + {31'h00000000, step}, q.per_sel);
				s.acc = '0;
				s.timer = '0;
			end else begin
				s.acc = q.acc + {31'h00000000, step};
				s.timer = q.timer + 25'h0000001;
			end
		end else begin
			s.acc = '0;
			s.timer = '0;
		end

		// bus: answer one cycle after the request is seen
		// read data is captured while idle so it stands from the answering edge
		case (q.bus)
			fast_pulse_counter_pkg::BUS_IDLE: begin
				if (req) begin
					s.bus = fast_pulse_counter_pkg::BUS_ACK;
				end
				case (AVS_ADDRESS)
					fast_pulse_counter_pkg::OFS_CTRL: s.rdata = {24'h000000, q.ctrl};
					fast_pulse_counter_pkg::OFS_NEW_DIR: s.rdata = {16'h0000, q.new_dir};
					fast_pulse_counter_pkg::OFS_REQUESTED_COUNT: s.rdata = q.requested_count;
					fast_pulse_counter_pkg::OFS_REQUESTED_REFERENCE: s.rdata = q.requested_reference;
					fast_pulse_counter_pkg::OFS_NEW_PERIOD: s.rdata = {16'h0000, q.new_period};
					fast_pulse_counter_pkg::OFS_STATUS: s.rdata = {16'h0000, q.status};
					fast_pulse_counter_pkg::OFS_EVENTS: s.rdata = {29'h00000000, q.sticky};
					fast_pulse_counter_pkg::OFS_COUNT: s.rdata = q.count;
					fast_pulse_counter_pkg::OFS_REF: s.rdata = q.refv;
					fast_pulse_counter_pkg::OFS_FREQ: s.rdata = q.freq;
					fast_pulse_counter_pkg::OFS_STATE: s.rdata = {27'h0000000, q.per_sel, q.out_active, q.last_down, q.dir_down};
					default: s.rdata = '0;
				endcase
			end
			fast_pulse_counter_pkg::BUS_ACK: s.bus = fast_pulse_counter_pkg::BUS_IDLE;
			default: s.bus = fast_pulse_counter_pkg::BUS_IDLE;
		endcase

		if (wr_fire) begin
			case (AVS_ADDRESS)
				fast_pulse_counter_pkg::OFS_CTRL: s.ctrl = merge({24'h000000, q.ctrl}, AVS_WRITEDATA, AVS_BYTEENABLE)
					[7:0];
				fast_pulse_counter_pkg::OFS_NEW_DIR: s.new_dir = merge({16'h0000, q.new_dir}, AVS_WRITEDATA,
					AVS_BYTEENABLE)[15:0];
				fast_pulse_counter_pkg::OFS_REQUESTED_COUNT: s.requested_count = merge(q.requested_count, AVS_WRITEDATA, AVS_BYTEENABLE);
				fast_pulse_counter_pkg::OFS_REQUESTED_REFERENCE: s.requested_reference = merge(q.requested_reference, AVS_WRITEDATA, AVS_BYTEENABLE);
				fast_pulse_counter_pkg::OFS_NEW_PERIOD: s.new_period = merge({16'h0000, q.new_period},
					AVS_WRITEDATA, AVS_BYTEENABLE)[15:0];
				default: s.status = q.status;
			endcase
		end

		// all flagged values in one step, none if any is illegal
		if (upd_fire) begin
			if (bad_dir) begin
				s.status = fast_pulse_counter_pkg::STAT_BAD_DIR;
			end else if (bad_per) begin
				s.status = fast_pulse_counter_pkg::STAT_BAD_PERIOD;
			end else begin
				s.status = fast_pulse_counter_pkg::STAT_OK;
				if (flags[fast_pulse_counter_pkg::UPD_DIR_BIT]) begin
					s.dir_down = q.new_dir == fast_pulse_counter_pkg::DIR_BWD;
				end
				// a software load wins over a same-cycle step, but not over a held reset
				if (flags[fast_pulse_counter_pkg::UPD_CV_BIT] && !rst_act) begin
					s.count = q.requested_count;
				end
				if (flags[fast_pulse_counter_pkg::UPD_RV_BIT]) begin
					s.refv = q.requested_reference;
				end
				if (flags[fast_pulse_counter_pkg::UPD_PER_BIT]) begin
					s.per_sel = q.new_period == fast_pulse_counter_pkg::NEW_PERIOD_10MS ? 2'h0 :
						q.new_period == fast_pulse_counter_pkg::NEW_PERIOD_100MS ? 2'h1 : 2'h2;
					s.acc = '0;
					s.timer = '0;
				end
			end
		end

		s.eq = s.count == s.refv;
		s.pulse.eq = s.eq && !q.eq;
		s.out_active = s.count < s.refv;
		// sticky events for software; set wins over clear
		s.sticky = q.sticky;
		if (wr_fire && AVS_ADDRESS == fast_pulse_counter_pkg::OFS_EVENTS) begin
			s.sticky = q.sticky & ~wmerged[2:0];
		end
		s.sticky = s.sticky | s.pulse;
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			q <= '0;
			q.bus <= fast_pulse_counter_pkg::BUS_IDLE;
			q.ctrl <= fast_pulse_counter_pkg::CTRL_RESET;
			q.count <= fast_pulse_counter_pkg::COUNT_RESET;
			q.refv <= fast_pulse_counter_pkg::REF_RESET;
			// zero count against zero reference must not fire an event at release
			q.eq <= 1'b1;
			q.status <= fast_pulse_counter_pkg::STAT_OK;
		end else begin
			q <= s;
		end
	end

	assign AVS_WAITREQUEST = req && q.bus != fast_pulse_counter_pkg::BUS_ACK;
	assign AVS_READDATA = q.rdata;
	assign OUT_ACTIVE = q.out_active;
	assign COUNT_VALUE = q.count;
	assign FREQ_VALUE = q.freq;
	assign EVENT_PULSE = q.pulse;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	a_reset_hold: assert property (rst_act |=> q.count == 0) else $error("count not held at zero");
	a_eq_once: assert property (q.pulse.eq |=> !q.pulse.eq) else $error("equal event repeated");
	a_eq_cause: assert property (q.pulse.eq |-> q.eq && !$past(q.eq)) else $error("equal event without cause");
	a_two_clk_up: assert property (mode == fast_pulse_counter_pkg::MODE_TWO_CLK && rise[1:0] == 2'b01 && !rst_act
		&& !upd_fire |=> q.count == $past(q.count) + 1) else $error("up clock did not increment");
	a_bad_dir: assert property (upd_fire && bad_dir |=> q.status == fast_pulse_counter_pkg::STAT_BAD_DIR
		&& q.dir_down == $past(q.dir_down)) else $error("illegal direction accepted");
	a_freq_blocked: assert property (!freq_mode |=> q.freq == $past(q.freq)) else $error("frequency outside mode");
	a_out_below: assert property (##1 q.out_active == ($past(s.count) < $past(s.refv)))
		else $error("output not tied to count below reference");
	a_pin_latency: assert property (!rst_act && !upd_fire && !$past(step) && !step |=> q.count == $past(q.count))
		else $error("count moved without an edge");
	a_bus_answer: assert property ($rose(req) && q.bus == fast_pulse_counter_pkg::BUS_IDLE |-> AVS_WAITREQUEST
		##1 !AVS_WAITREQUEST) else $error("bus answer not after one cycle");
	a_sticky_wins: assert property (s.pulse.eq |=> q.sticky.eq) else $error("equal event lost in clear");
	a_bad_period: assert property (upd_fire && !bad_dir && bad_per
		|=> q.status == fast_pulse_counter_pkg::STAT_BAD_PERIOD && q.per_sel == $past(q.per_sel))
		else $error("illegal period accepted");
	a_rst_event: assert property ($rose(rst_act) |=> q.pulse.rst) else $error("reset event missing");

	c_quad_step: cover property (mode == fast_pulse_counter_pkg::MODE_QUAD && step);
	c_freq_pub: cover property (freq_mode && q.timer == 0 ##1 q.freq != 0);
	c_reset_event: cover property (q.pulse.rst);
	c_dir_change: cover property (q.pulse.dir);
	c_update_ok: cover property (upd_fire && !bad_dir && !bad_per);
endmodule

// ==== verilog/fast_pulse_counter_pkg.sv ====
// Purpose: shared constants and types of the fast pulse counter
// Assumes: 25 MHz system clock, 32-bit Avalon-MM register slave
// Notes:   register offsets are byte addresses, one aligned word each
package fast_pulse_counter_pkg;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLOCK_HZ = 25000000;
	localparam int PERIOD_10MS_US = 10000;
	localparam int PERIOD_100MS_US = 100000;
	localparam int PERIOD_1S_US = 1000000;
	localparam int TICKS_10MS = PERIOD_10MS_US * (CLOCK_HZ / 1000000);
	localparam int TICKS_100MS = PERIOD_100MS_US * (CLOCK_HZ / 1000000);
	localparam int TICKS_1S = PERIOD_1S_US * (CLOCK_HZ / 1000000);
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [5:0] OFS_CTRL = 6'h00;
	localparam logic [5:0] OFS_UPDATE = 6'h04;
	localparam logic [5:0] OFS_NEW_DIR = 6'h08;
	localparam logic [5:0] OFS_REQUESTED_COUNT = 6'h0C;
	localparam logic [5:0] OFS_REQUESTED_REFERENCE = 6'h10;
	localparam logic [5:0] OFS_NEW_PERIOD = 6'h14;
	localparam logic [5:0] OFS_STATUS = 6'h18;
	localparam logic [5:0] OFS_EVENTS = 6'h1C;
	localparam logic [5:0] OFS_COUNT = 6'h20;
	localparam logic [5:0] OFS_REF = 6'h24;
	localparam logic [5:0] OFS_FREQ = 6'h28;
	localparam logic [5:0] OFS_STATE = 6'h2C;
	localparam int CTRL_RST_EN_BIT = 4;
	localparam int CTRL_RST_HIGH_BIT = 5;
	localparam int CTRL_FREQ_BIT = 6;
	localparam int UPD_DIR_BIT = 0;
	localparam int UPD_CV_BIT = 1;
	localparam int UPD_RV_BIT = 2;
	localparam int UPD_PER_BIT = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [31:0] COUNT_RESET = 32'h00000000;
	localparam logic [31:0] REF_RESET = 32'h00000000;
	localparam logic [15:0] DIR_FWD = 16'h0001;
	localparam logic [15:0] DIR_BWD = 16'hFFFF;
	localparam logic [15:0] NEW_PERIOD_10MS = 16'h000A;
	localparam logic [15:0] NEW_PERIOD_100MS = 16'h0064;
	localparam logic [15:0] NEW_PERIOD_1S = 16'h03E8;
	localparam logic [15:0] STAT_OK = 16'h0000;
	localparam logic [15:0] STAT_BAD_DIR = 16'h80B1;
	localparam logic [15:0] STAT_BAD_PERIOD = 16'h80B4;
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [2:0] {
		MODE_INT_DIR = 3'h0,
		MODE_EXT_DIR = 3'h1,
		MODE_TWO_CLK = 3'h2,
		MODE_QUAD = 3'h3,
		MODE_PTO_MON = 3'h4
	} mode_t;
	typedef enum logic [1:0] {BUS_IDLE = 2'b01, BUS_ACK = 2'b10} bus_t;
	typedef struct packed {
		logic dir;
		logic rst;
		logic eq;
	} events_t;
	typedef struct packed {
		bus_t bus;
		logic [31:0] rdata;
		logic [2:0] sync1;
		logic [2:0] sync2;
		logic [2:0] prev;
		logic [7:0] ctrl;
		logic [15:0] new_dir;
		logic [31:0] requested_count;
		logic [31:0] requested_reference;
		logic [15:0] new_period;
		logic [1:0] per_sel;
		logic signed [31:0] count;
		logic signed [31:0] refv;
		logic dir_down;
		logic last_down;
		logic eq;
		logic rst_prev;
		logic [31:0] freq;
		logic [31:0] acc;
		logic [24:0] timer;
		logic [15:0] status;
		events_t sticky;
		events_t pulse;
		logic out_active;
	} state_t;
endpackage
